// file: rtl/dhi_dev.sv
module dhi_dev
   import dhi_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   dhi_if.device link,
   input wire logic rgb_en,
   input wire logic pix_fmt16,
   input wire logic [DHI_BUS_W-1:0] rd_data,
   output logic word_valid,
   output logic word_is_data,
   output logic [DHI_BUS_W-1:0] word_data,
   output logic pix_valid,
   output logic [DHI_BUS_W-1:0] pix_data,
   output logic [DHI_COL_W-1:0] pix_col,
   output logic [DHI_ROW_W-1:0] pix_row,
   output logic [2:0] iface_mode
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   localparam int PIN_W = 13 + DHI_BUS_W; // control pins plus bus

   logic [PIN_W-1:0] pin_raw; // pins as they arrive
   logic [PIN_W-1:0] pin_s1; // first stage, read by pin_s2 only
   logic [PIN_W-1:0] pin_s2; // settled copy
   logic [PIN_W-1:0] pin_d; // settled copy one cycle older

   assign pin_raw = {link.reset_n, link.iface_sel_b2, link.iface_sel_b1,
                     link.iface_sel_b0, link.cs_n, link.data_cmd_sel,
                     link.write_strobe_n, link.read_strobe_n, link.vsync_n,
                     link.hsync_n, link.data_en, link.pixel_clock,
                     link.serial_in_lane0, link.parallel_data_bus};

   // two flops on everything from the far side
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_d <= '0;
      end
      else
      begin
         pin_s1 <= pin_raw;
         pin_s2 <= pin_s1;
         pin_d <= pin_s2;
      end
   end

   // ---------------------------------------------------------------
   // named views of the settled pins
   // ---------------------------------------------------------------
   logic pin_rst_n; // device reset pin
   logic [2:0] pin_sel; // strap bits
   logic cs_act; // chip selected
   logic cs_fall; // select just asserted
   logic dc_lvl; // data/command level
   logic scl_rise; // serial clock rising
   logic scl_fall; // serial clock falling
   logic wr_lvl; // strobe pin level
   logic wr_rise; // write strobe released
   logic rd_act; // read strobe low
   logic vs_act; // frame sync asserted
   logic hs_act; // line sync asserted
   logic de_lvl; // pixel qualifier
   logic pclk_rise; // pixel clock rising
   logic lane0; // serial lane level
   logic [DHI_BUS_W-1:0] bus_lvl; // bus level

   assign pin_rst_n = pin_s2[PIN_W-1];
   assign pin_sel = pin_s2[PIN_W-2 -: 3];
   assign cs_act = !pin_s2[PIN_W-5];
   assign cs_fall = pin_d[PIN_W-5] && !pin_s2[PIN_W-5];
   assign dc_lvl = pin_s2[PIN_W-6];
   assign scl_rise = !pin_d[PIN_W-6] && pin_s2[PIN_W-6];
   assign scl_fall = pin_d[PIN_W-6] && !pin_s2[PIN_W-6];
   assign wr_lvl = pin_s2[PIN_W-7];
   assign wr_rise = !pin_d[PIN_W-7] && pin_s2[PIN_W-7];
   assign rd_act = !pin_s2[PIN_W-8];
   assign vs_act = !pin_s2[PIN_W-9];
   assign hs_act = !pin_s2[PIN_W-10];
   assign de_lvl = pin_s2[PIN_W-11];
   assign pclk_rise = !pin_d[PIN_W-12] && pin_s2[PIN_W-12];
   assign lane0 = pin_s2[PIN_W-13];
   assign bus_lvl = pin_s2[DHI_BUS_W-1:0];

   // ---------------------------------------------------------------
   // interface strap capture
   // ---------------------------------------------------------------
   logic serial_mode; // any serial strap code
   logic par_mode; // parallel bus active

   // straps follow the pins while the device is held in reset
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         iface_mode <= DHI_MODE_PAR;
      else if (!pin_rst_n)
         iface_mode <= pin_sel;
   end

   assign serial_mode = iface_mode == DHI_MODE_SER3 ||
                        iface_mode == DHI_MODE_SER4 ||
                        iface_mode == DHI_MODE_SER2;
   // video shares the bus, so parallel decode stays off with it
   assign par_mode = iface_mode == DHI_MODE_PAR && !rgb_en;

   // ---------------------------------------------------------------
   // serial receive
   // ---------------------------------------------------------------
   logic [3:0] bit_cnt; // clocks taken in this word
   logic [8:0] rx_sh; // bits gathered so far
   logic ser_done; // last clock of a word
   logic ser_dc; // dc of the finished word
   logic [7:0] ser_byte; // payload of the finished word

   always_comb
   begin
      ser_done = 1'b0;
      ser_dc = 1'b0;
      ser_byte = {rx_sh[6:0], lane0};
      unique case (iface_mode)
         DHI_MODE_SER3:
         begin
            ser_done = bit_cnt == 4'h8; // dc then eight bits
            ser_dc = rx_sh[7];
         end
         DHI_MODE_SER4:
         begin
            ser_done = bit_cnt == 4'h7;
            ser_dc = wr_lvl;
         end
         DHI_MODE_SER2:
         begin
            ser_done = bit_cnt == 4'h4; // dc then four pairs
            ser_dc = rx_sh[6];
            ser_byte = {rx_sh[5:0], lane0, wr_lvl};
         end
         default:
         begin
            ser_done = 1'b0; // parallel or unused code
         end
      endcase
   end

   // shift on each rising serial clock while selected
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt <= 4'h0;
         rx_sh <= 9'h000;
      end
      else if (!pin_rst_n || !cs_act || !serial_mode)
      begin
         bit_cnt <= 4'h0; // deselect aborts a partial word
         rx_sh <= 9'h000;
      end
      else if (scl_rise)
      begin
         if (ser_done)
            bit_cnt <= 4'h0;
         else
            bit_cnt <= bit_cnt + 4'h1;
         if (iface_mode == DHI_MODE_SER2 && bit_cnt != 4'h0)
            rx_sh <= {rx_sh[6:0], lane0, wr_lvl};
         else
            rx_sh <= {rx_sh[7:0], lane0};
      end
   end

   // ---------------------------------------------------------------
   // received word output
   // ---------------------------------------------------------------
   // one pulse per word; parallel words come on the write strobe end
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_valid <= 1'b0;
         word_is_data <= 1'b0;
         word_data <= '0;
      end
      else
      begin
         word_valid <= 1'b0;
         if (pin_rst_n && cs_act && par_mode && wr_rise)
         begin
            word_valid <= 1'b1;
            word_is_data <= dc_lvl;
            word_data <= bus_lvl;
         end
         else if (pin_rst_n && cs_act && serial_mode && scl_rise &&
                  ser_done)
         begin
            word_valid <= 1'b1;
            word_is_data <= ser_dc;
            word_data <= {{(DHI_BUS_W-DHI_SER_BITS){1'b0}}, ser_byte};
         end
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   logic [7:0] tx_sh; // serial read bits still to send

   // bus is driven only while selected and the read strobe is low;
   // the host latches on the strobe's rising edge, so data must hold
   // until the strobe is seen high here
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link.dev_bus_oe <= 1'b0;
         link.dev_bus_out <= '0;
      end
      else
      begin
         link.dev_bus_oe <= pin_rst_n && cs_act && par_mode && rd_act;
         link.dev_bus_out <= rd_data;
      end
   end

   // low byte shifted out msb first, one bit per falling clock
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_sh <= 8'h00;
         link.serial_out_line <= 1'b0;
      end
      else if (!pin_rst_n || !serial_mode)
      begin
         tx_sh <= 8'h00;
         link.serial_out_line <= 1'b0;
      end
      else if (cs_fall)
         tx_sh <= rd_data[7:0]; // snapshot at select
      else if (cs_act && scl_fall)
      begin
         link.serial_out_line <= tx_sh[7];
         tx_sh <= {tx_sh[6:0], 1'b0};
      end
   end

   // ---------------------------------------------------------------
   // video pixel capture
   // ---------------------------------------------------------------
   // sync pins low on a pixel restart its frame or line
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pix_valid <= 1'b0;
         pix_data <= '0;
         pix_col <= '0;
         pix_row <= '0;
      end
      else
      begin
         pix_valid <= 1'b0;
         if (pin_rst_n && rgb_en && pclk_rise && de_lvl)
         begin
            pix_valid <= 1'b1;
            // narrow format keeps only sixteen bits
            pix_data <= pix_fmt16 ? {2'h0, bus_lvl[15:0]} : bus_lvl;
            if (vs_act)
            begin
               pix_col <= '0;
               pix_row <= '0;
            end
            else if (hs_act || pix_col == DHI_COL_W'(DHI_COLS - 1))
            begin
               pix_col <= '0;
               if (pix_row == DHI_ROW_W'(DHI_ROWS - 1))
                  pix_row <= '0;
               else
                  pix_row <= pix_row + 1'b1;
            end
            else
               pix_col <= pix_col + 1'b1;
         end
      end
   end
endmodule : dhi_dev

// file: inc/dhi_pkg.sv
package dhi_pkg;
   // ---------------------------------------------------------------
   // link geometry
   // ---------------------------------------------------------------
   localparam int DHI_BUS_W = 18; // shared parallel / pixel bus
   localparam int DHI_COLS = 240; // pixel columns
   localparam int DHI_ROWS = 320; // pixel rows
   localparam int DHI_COL_W = 8; // column counter width
   localparam int DHI_ROW_W = 9; // row counter width
   localparam int DHI_SER_BITS = 8; // payload bits per serial word

   // ---------------------------------------------------------------
   // interface strap codes
   // ---------------------------------------------------------------
   localparam logic [2:0] DHI_MODE_PAR = 3'h0; // parallel bus
   localparam logic [2:0] DHI_MODE_SER3 = 3'h5; // 3-line, dc bit first
   localparam logic [2:0] DHI_MODE_SER4 = 3'h6; // 4-line, dc on strobe pin
   localparam logic [2:0] DHI_MODE_SER2 = 3'h7; // 2-lane serial

   // ---------------------------------------------------------------
   // host request kinds
   // ---------------------------------------------------------------
   localparam logic [1:0] DHI_KIND_WR = 2'h0; // command or data write
   localparam logic [1:0] DHI_KIND_RD = 2'h1; // parallel read
   localparam logic [1:0] DHI_KIND_PIX = 2'h2; // video pixel

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int DHI_CLK_NS = 40; // system clock period
   localparam int DHI_HALF_NS = 320; // least link clock half period
   localparam int DHI_HALF_CYC = (DHI_HALF_NS + DHI_CLK_NS - 1) / DHI_CLK_NS;
   localparam int DHI_RST_NS = 1000; // least device reset pulse
   localparam int DHI_RST_CYC = (DHI_RST_NS + DHI_CLK_NS - 1) / DHI_CLK_NS;
endpackage : dhi_pkg

// file: inc/dhi_if.sv
interface dhi_if;
   import dhi_pkg::*;
   // ---------------------------------------------------------------
   // pins between host and display
   // ---------------------------------------------------------------
   logic reset_n; // device reset, low active
   logic iface_sel_b2; // interface strap bits
   logic iface_sel_b1;
   logic iface_sel_b0;
   logic cs_n; // chip select
   logic data_cmd_sel; // data/command level, or serial clock
   logic write_strobe_n; // write strobe / serial dc / second lane
   logic read_strobe_n; // read strobe
   logic vsync_n; // frame sync
   logic hsync_n; // line sync
   logic data_en; // pixel qualifier
   logic pixel_clock; // pixel clock
   logic serial_in_lane0; // serial data lane
   logic serial_out_line; // serial read data
   logic [DHI_BUS_W-1:0] host_bus_out; // host drive value
   logic host_bus_oe; // host drives bus
   logic [DHI_BUS_W-1:0] dev_bus_out; // device drive value
   logic dev_bus_oe; // device drives bus
   logic [DHI_BUS_W-1:0] parallel_data_bus; // resolved bus level

   // unused bus settles low
   assign parallel_data_bus = host_bus_oe ? host_bus_out :
                              dev_bus_oe ? dev_bus_out : '0;

   modport host (
      output reset_n, iface_sel_b2, iface_sel_b1, iface_sel_b0, cs_n,
      output data_cmd_sel, write_strobe_n, read_strobe_n, vsync_n,
      output hsync_n, data_en, pixel_clock, serial_in_lane0,
      output host_bus_out, host_bus_oe,
      input serial_out_line, parallel_data_bus
   );
   modport device (
      input reset_n, iface_sel_b2, iface_sel_b1, iface_sel_b0, cs_n,
      input data_cmd_sel, write_strobe_n, read_strobe_n, vsync_n,
      input hsync_n, data_en, pixel_clock, serial_in_lane0,
      input parallel_data_bus,
      output serial_out_line, dev_bus_out, dev_bus_oe
   );
endinterface : dhi_if

// file: rtl/dhi_host.sv
module dhi_host
   import dhi_pkg::*;
#(
   parameter int HALF_CYC = DHI_HALF_CYC,
   parameter int RST_CYC = DHI_RST_CYC
)
(
   input wire logic clock,
   input wire logic rst_n,
   dhi_if.host link,
   input wire logic [2:0] mode,
   input wire logic req_valid,
   input wire logic [1:0] req_kind,
   input wire logic req_is_data,
   input wire logic req_sof,
   input wire logic req_sol,
   input wire logic [DHI_BUS_W-1:0] req_data,
   output logic req_ready,
   output logic rd_valid,
   output logic [DHI_BUS_W-1:0] rd_word
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_RST = 5'h01, ST_IDLE = 5'h02, ST_LOW = 5'h04,
      ST_HIGH = 5'h08, ST_GAP = 5'h10
   } dhi_state_e;

   dhi_state_e state; // transfer phase
   logic [15:0] ph; // cycles spent in this phase
   logic [3:0] shots; // strobes still to give
   logic [17:0] tx; // serial bits, next one on top
   logic [1:0] kind; // kind of current transfer
   logic dc_bit; // data/command of current transfer
   logic sof; // frame start flag
   logic sol; // line start flag
   logic [DHI_BUS_W-1:0] data; // word in flight
   logic serial; // transfer goes over the serial lanes
   logic accept; // request taken this cycle
   logic ph_end; // last cycle of a phase
   logic go_low; // strobe falls next
   logic go_high; // strobe rises next
   logic go_end; // transfer finishes
   logic [DHI_BUS_W-1:0] bus_s1; // bus sync, first stage
   logic [DHI_BUS_W-1:0] bus_s2; // bus sync, settled

   assign accept = state == ST_IDLE && req_valid && req_ready;
   assign ph_end = ph == 16'(HALF_CYC - 1);
   assign serial = kind == DHI_KIND_WR && mode != DHI_MODE_PAR;
   assign go_low = accept || (state == ST_HIGH && ph_end && shots != 4'h1);
   assign go_high = state == ST_LOW && ph_end;
   assign go_end = state == ST_HIGH && ph_end && shots == 4'h1;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // reset pulse first, then strobes of HALF_CYC low and high
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_RST;
         ph <= 16'h0000;
         shots <= 4'h0;
         tx <= 18'h00000;
         kind <= DHI_KIND_WR;
         dc_bit <= 1'b0;
         sof <= 1'b0;
         sol <= 1'b0;
         data <= '0;
      end
      else if (accept)
      begin
         state <= ST_LOW;
         ph <= 16'h0000;
         kind <= req_kind;
         dc_bit <= req_is_data;
         sof <= req_sof;
         sol <= req_sol;
         data <= req_data;
         shots <= 4'h1;
         tx <= {req_is_data, req_data[7:0], 9'h000};
         if (req_kind == DHI_KIND_WR && mode == DHI_MODE_SER3)
            shots <= 4'h9;
         else if (req_kind == DHI_KIND_WR && mode == DHI_MODE_SER4)
         begin
            shots <= 4'h8;
            tx <= {req_data[7:0], 10'h000};
         end
         else if (req_kind == DHI_KIND_WR && mode == DHI_MODE_SER2)
         begin
            shots <= 4'h5;
            tx <= {req_is_data, 1'b0, req_data[7:0], 8'h00};
         end
      end
      else
      begin
         ph <= ph + 16'h0001;
         unique case (state)
            ST_RST:
               if (ph == 16'(RST_CYC - 1))
               begin
                  state <= ST_GAP;
                  ph <= 16'h0000;
               end
            ST_IDLE:
               ph <= 16'h0000;
            ST_LOW:
               if (ph_end)
               begin
                  state <= ST_HIGH;
                  ph <= 16'h0000;
               end
            ST_HIGH:
               if (ph_end)
               begin
                  ph <= 16'h0000;
                  shots <= shots - 4'h1;
                  state <= go_end ? ST_GAP : ST_LOW;
                  tx <= mode == DHI_MODE_SER2 ? {tx[15:0], 2'h0} :
                        {tx[16:0], 1'b0};
               end
            ST_GAP:
               if (ph_end)
               begin
                  state <= ST_IDLE;
                  ph <= 16'h0000;
               end
         endcase
      end
   end

   // ready only in idle, so a request waits out the gap
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         req_ready <= 1'b0;
      else
         req_ready <= (state == ST_GAP && ph_end) ||
                      (state == ST_IDLE && !accept);
   end

   // ---------------------------------------------------------------
   // pins
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link.reset_n <= 1'b0;
         {link.iface_sel_b2, link.iface_sel_b1, link.iface_sel_b0} <= 3'h0;
         link.cs_n <= 1'b1;
         link.data_cmd_sel <= 1'b1;
         link.write_strobe_n <= 1'b1;
         link.read_strobe_n <= 1'b1;
         link.vsync_n <= 1'b1;
         link.hsync_n <= 1'b1;
         link.data_en <= 1'b0;
         link.pixel_clock <= 1'b1;
         link.serial_in_lane0 <= 1'b0;
         link.host_bus_out <= '0;
         link.host_bus_oe <= 1'b0;
      end
      else
      begin
         link.reset_n <= state != ST_RST;
         {link.iface_sel_b2, link.iface_sel_b1, link.iface_sel_b0} <= mode;
         if (go_low && accept && req_kind == DHI_KIND_PIX)
         begin
            link.pixel_clock <= 1'b0;
            link.data_en <= 1'b1;
            link.vsync_n <= !req_sof;
            link.hsync_n <= !req_sol;
            link.host_bus_out <= req_data;
            link.host_bus_oe <= 1'b1;
         end
         else if (go_low && !accept && kind == DHI_KIND_PIX)
            link.pixel_clock <= 1'b0;
         else if (go_low && accept)
         begin
            link.cs_n <= 1'b0;
            link.data_cmd_sel <= req_is_data;
            if (req_kind == DHI_KIND_RD)
               link.read_strobe_n <= 1'b0;
            else if (mode == DHI_MODE_PAR)
            begin
               link.write_strobe_n <= 1'b0;
               link.host_bus_out <= req_data;
               link.host_bus_oe <= 1'b1;
            end
            else
            begin
               link.data_cmd_sel <= 1'b0;
               link.serial_in_lane0 <= mode == DHI_MODE_SER4 ?
                                       req_data[7] : req_is_data;
               link.write_strobe_n <= mode == DHI_MODE_SER4 ?
                                      req_is_data : 1'b0;
            end
         end
         else if (go_low && serial)
         begin
            link.data_cmd_sel <= 1'b0;
            // tx shifts on this same edge, so read one place ahead
            link.serial_in_lane0 <= mode == DHI_MODE_SER2 ? tx[15] : tx[16];
            if (mode == DHI_MODE_SER2)
               link.write_strobe_n <= tx[14];
         end
         else if (go_high)
         begin
            link.pixel_clock <= 1'b1;
            link.read_strobe_n <= 1'b1;
            link.data_cmd_sel <= serial ? 1'b1 : dc_bit;
            if (!serial)
               link.write_strobe_n <= 1'b1;
         end
         else if (go_end)
         begin
            link.cs_n <= 1'b1;
            link.data_cmd_sel <= 1'b1;
            link.write_strobe_n <= 1'b1;
            link.data_en <= 1'b0;
            link.vsync_n <= 1'b1;
            link.hsync_n <= 1'b1;
            link.host_bus_oe <= 1'b0;
            link.host_bus_out <= '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // read capture
   // ---------------------------------------------------------------
   // latch the settled bus in the cycle the read strobe is raised
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_s1 <= '0;
         bus_s2 <= '0;
         rd_valid <= 1'b0;
         rd_word <= '0;
      end
      else
      begin
         bus_s1 <= link.parallel_data_bus;
         bus_s2 <= bus_s1;
         rd_valid <= go_high && kind == DHI_KIND_RD;
         if (go_high && kind == DHI_KIND_RD)
            rd_word <= bus_s2;
      end
   end
endmodule : dhi_host

// file: verif/dhi_assertions.sv
// ------------------------------------------------------------
// pin-level checks between the two ends
// ------------------------------------------------------------
module dhi_assertions
   import dhi_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic data_cmd_sel,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic pixel_clock,
   input wire logic host_bus_oe,
   input wire logic dev_bus_oe,
   input wire logic [DHI_BUS_W-1:0] parallel_data_bus
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // device lets go of the bus within its sync lag
   property p_cs_off; $rose(cs_n) |-> ##[0:4] !dev_bus_oe; endproperty
   a_cs_off: assert property (p_cs_off) else $error("bus kept");
   property p_rd_on;
      $fell(read_strobe_n) && !cs_n |-> ##[1:4] dev_bus_oe;
   endproperty
   a_rd_on: assert property (p_rd_on) else $error("no read drive");
   // two drivers on the shared bus would short it
   property p_one_drv; !(host_bus_oe && dev_bus_oe); endproperty
   a_one_drv: assert property (p_one_drv) else $error("bus clash");
   property p_wr_len;
      $fell(write_strobe_n) && host_bus_oe
         |-> !write_strobe_n [*8] ##1 write_strobe_n;
   endproperty
   a_wr_len: assert property (p_wr_len) else $error("strobe len");
   property p_wr_hold;
      host_bus_oe && !write_strobe_n && !$past(write_strobe_n)
         |-> $stable(data_cmd_sel) && $stable(parallel_data_bus);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("dc moved");
   // serial clock low phase is one half period
   property p_sclk;
      $fell(data_cmd_sel) && !cs_n && !host_bus_oe && read_strobe_n
         |-> !data_cmd_sel [*8];
   endproperty
   a_sclk: assert property (p_sclk) else $error("sclk low len");
   property p_quiet; !reset_n |-> cs_n && read_strobe_n; endproperty
   a_quiet: assert property (p_quiet) else $error("access in reset");
   property p_pix;
      $rose(pixel_clock) |-> cs_n && $stable(parallel_data_bus);
   endproperty
   a_pix: assert property (p_pix) else $error("pixel bus moved");
endmodule : dhi_assertions

// file: verif/display_host_interface_tb_top.sv
`define CHK(nm, e, g) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("MISMATCH %s exp %h got %h", nm, e, g); \
      end \
   end
// ------------------------------------------------------------
// host end and device end back to back
// ------------------------------------------------------------
module display_host_interface_tb_top
   import dhi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_is_data = 1'b0;
   logic req_sof = 1'b0, req_sol = 1'b0, rgb_en = 1'b0, pix_fmt16 = 1'b0;
   logic [2:0] mode = DHI_MODE_PAR;
   logic [1:0] req_kind = DHI_KIND_WR;
   logic [DHI_BUS_W-1:0] req_data = '0, rd_data = '0, rd_word, word_data;
   logic [DHI_BUS_W-1:0] pix_data;
   logic req_ready, rd_valid, word_valid, word_is_data, pix_valid;
   logic [DHI_COL_W-1:0] pix_col;
   logic [DHI_ROW_W-1:0] pix_row;
   logic [2:0] iface_mode;
   logic [7:0] so_sh = 8'h00; // serial read bits seen by the host
   logic [2:0] smode [3] = '{DHI_MODE_SER3, DHI_MODE_SER4, DHI_MODE_SER2};
   int n_fail = 0, samples_checked = 0;
   always #20 clock = ~clock;
   dhi_if link ();
   dhi_host i_dhi_host (.clock, .rst_n, .link, .mode, .req_valid, .req_kind,
      .req_is_data, .req_sof, .req_sol, .req_data, .req_ready, .rd_valid,
      .rd_word);
   dhi_dev i_dhi_dev (.clock, .rst_n, .link, .rgb_en, .pix_fmt16, .rd_data,
      .word_valid, .word_is_data, .word_data, .pix_valid, .pix_data,
      .pix_col, .pix_row, .iface_mode);
   dhi_assertions u_chk (.clock, .rst_n, .reset_n(link.reset_n),
      .cs_n(link.cs_n), .data_cmd_sel(link.data_cmd_sel),
      .write_strobe_n(link.write_strobe_n),
      .read_strobe_n(link.read_strobe_n), .pixel_clock(link.pixel_clock),
      .host_bus_oe(link.host_bus_oe), .dev_bus_oe(link.dev_bus_oe),
      .parallel_data_bus(link.parallel_data_bus));
   task automatic final_report;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   // bounded wait: 0 word, 1 read, 2 pixel, 3 ready
   task automatic wait_on(input int sel);
      int n;
      logic [3:0] f;
      n = 0;
      f = '0;
      while (f[sel] !== 1'b1)
      begin
         @(negedge clock);
         f = {req_ready, pix_valid, rd_valid, word_valid};
         n++;
         if (n > 2000)
         begin
            n_fail++;
            final_report();
         end
      end
   endtask : wait_on
   // straps only latch while the device reset pin is low
   task automatic restart(input logic [2:0] m);
      rst_n = 1'b0;
      mode = m;
      repeat (12) @(negedge clock);
      rst_n = 1'b1;
      wait_on(3);
   endtask : restart
   task automatic xfer(input logic [1:0] k, input logic d, input logic s,
                       input logic [DHI_BUS_W-1:0] v);
      wait_on(3);
      req_kind = k;
      req_is_data = d;
      req_sof = s;
      req_sol = s;
      req_data = v;
      req_valid = 1'b1;
      @(negedge clock);
      req_valid = 1'b0;
      wait_on(k);
   endtask : xfer
   // read bits taken on each rising serial clock while selected
   always @(posedge link.data_cmd_sel)
      if (!link.cs_n)
         so_sh <= {so_sh[6:0], link.serial_out_line};
   initial
   begin
      restart(DHI_MODE_PAR);
      xfer(DHI_KIND_WR, 1'b0, 1'b0, 18'h0002c);
      `CHK("cmd flag", 1'b0, word_is_data)
      xfer(DHI_KIND_WR, 1'b1, 1'b0, 18'h3a5c3);
      `CHK("data flag", 1'b1, word_is_data)
      `CHK("data word", 18'h3a5c3, word_data)
      rd_data = 18'h25a5a;
      xfer(DHI_KIND_RD, 1'b1, 1'b0, 18'h00000);
      `CHK("read word", 18'h25a5a, rd_word)
      foreach (smode[i])
      begin
         restart(smode[i]);
         `CHK("straps", smode[i], iface_mode)
         xfer(DHI_KIND_WR, i[0], 1'b0, 18'h000c3);
         `CHK("ser flag", i[0], word_is_data)
         `CHK("ser word", 18'h000c3, word_data)
         // nine clocks: first holds a stale bit, then the low read byte
         if (smode[i] == DHI_MODE_SER3)
            `CHK("ser out", 8'h5a, so_sh)
      end
      rgb_en = 1'b1;
      pix_fmt16 = 1'b1;
      xfer(DHI_KIND_PIX, 1'b1, 1'b1, 18'h3ffff);
      `CHK("pix 16", 18'h0ffff, pix_data)
      pix_fmt16 = 1'b0;
      xfer(DHI_KIND_PIX, 1'b1, 1'b0, 18'h12345);
      `CHK("pix 18", 18'h12345, pix_data)
      `CHK("pix col", 8'h01, pix_col)
      `CHK("pix row", 9'h000, pix_row)
      final_report();
   end
endmodule : display_host_interface_tb_top
